// >>> rtl/tcio_top.sv
`timescale 1ns/100ps
// Channel 0 register-function control for general registers A to D.
// Index 0..3 of every vector is register A, B, C, D in that order.
module tcio_top #(
    parameter int CNT_W = 16
) (
    input  logic             clock,
    input  logic             rst,
    input  logic             standby,
    input  logic [3:0]       reg_addr,
    input  logic [15:0]      reg_wdata,
    input  logic             reg_write,
    input  logic             reg_read,
    output logic [15:0]      reg_rdata,
    input  logic [CNT_W-1:0] ch0_count,
    input  logic             ch1_count_step,
    input  logic             buffer_a_enable,
    input  logic             buffer_b_enable,
    input  logic [3:0]       ch0_pin_in,
    output logic [3:0]       ch0_pin_out,
    output logic [3:0]       ch0_pin_oe,
    output logic [3:0]       match_pulse,
    output logic [3:0]       capture_pulse
);
    localparam int NUM_GR = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration checks.

    // The register port carries 16 bits, so a wider counter could not be read back.
    if (CNT_W < 2 || CNT_W > 16)
    begin : g_bad_width
        $error("tcio_top: CNT_W must lie between 2 and 16.");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic [7:0]       ch0_io_select_high;
    logic [7:0]       ch0_io_select_low;
    logic [7:0]       next_select_high;
    logic [7:0]       next_select_low;
    logic [CNT_W-1:0] gr       [NUM_GR];
    logic [CNT_W-1:0] next_gr  [NUM_GR];
    logic [15:0]      next_rdata;
    logic [3:0]       fields   [NUM_GR];
    logic [NUM_GR-1:0] field_load;
    logic [NUM_GR-1:0] buffered;
    logic [NUM_GR-1:0] lvl;
    logic [NUM_GR-1:0] oe;
    logic [NUM_GR-1:0] cap_mode;
    logic [NUM_GR-1:0] next_field_load;
    logic [NUM_GR-1:0] field_load_q;
    logic [15:0]      status_word;
    logic [CNT_W-1:0] cap_word [NUM_GR];

    tcio_ch_if #(.CNT_W(CNT_W)) chan [NUM_GR] ();

    ////////////////////////////////////////////////////////////////////////////////
    // Decode helpers.

    // True when the strobe addresses the given offset.
    function automatic logic hit(input logic strobe,
                                 input logic [3:0] addr,
                                 input logic [3:0] ofs);
        hit = strobe && (addr == ofs);
    endfunction

    // Offset of general register A..D by index.
    function automatic logic [3:0] gr_offset(input int idx);
        unique case (idx)
            0:       gr_offset = tcio_pkg::OFS_GR_A;
            1:       gr_offset = tcio_pkg::OFS_GR_B;
            2:       gr_offset = tcio_pkg::OFS_GR_C;
            default: gr_offset = tcio_pkg::OFS_GR_D;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Field routing.

    // High select holds A in the low nibble and B in the high nibble.
    assign fields[0] = ch0_io_select_high[tcio_pkg::FIELD_LO_LSB +: tcio_pkg::FIELD_W];
    assign fields[1] = ch0_io_select_high[tcio_pkg::FIELD_HI_LSB +: tcio_pkg::FIELD_W];
    // Low select holds C in the low nibble and D in the high nibble.
    assign fields[2] = ch0_io_select_low[tcio_pkg::FIELD_LO_LSB +: tcio_pkg::FIELD_W];
    assign fields[3] = ch0_io_select_low[tcio_pkg::FIELD_HI_LSB +: tcio_pkg::FIELD_W];

    // Buffer mode takes C and D out of service; A and B never are.
    assign buffered[0] = 1'b0;
    assign buffered[1] = 1'b0;
    assign buffered[2] = buffer_a_enable;
    assign buffered[3] = buffer_b_enable;

    ////////////////////////////////////////////////////////////////////////////////
    // Select registers.

    // Standby clears the selects like power-on reset; no other reset touches them.
    always_comb
    begin
        next_select_high = ch0_io_select_high;
        next_select_low  = ch0_io_select_low;
        next_field_load  = '0;
        if (standby)
        begin
            next_select_high = tcio_pkg::SEL_RESET;
            next_select_low  = tcio_pkg::SEL_RESET;
            next_field_load  = '1;
        end
        else
        begin
            if (hit(reg_write, reg_addr, tcio_pkg::OFS_SEL_HIGH))
            begin
                next_select_high = reg_wdata[7:0];
                next_field_load[0] = 1'b1;
                next_field_load[1] = 1'b1;
            end
            if (hit(reg_write, reg_addr, tcio_pkg::OFS_SEL_LOW))
            begin
                next_select_low = reg_wdata[7:0];
                next_field_load[2] = 1'b1;
                next_field_load[3] = 1'b1;
            end
        end
    end

    // Reset gives code 0000 in every field.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ch0_io_select_high <= tcio_pkg::SEL_RESET;
            ch0_io_select_low  <= tcio_pkg::SEL_RESET;
            field_load_q       <= '1;
        end
        else
        begin
            ch0_io_select_high <= next_select_high;
            ch0_io_select_low  <= next_select_low;
            field_load_q       <= next_field_load;
        end
    end

    // The load strobe is registered in the same cycle as the new field, so units see both together.
    assign field_load = field_load_q;

    ////////////////////////////////////////////////////////////////////////////////
    // General registers.

    // A capture beats a software write landing in the same cycle.
    always_comb
    begin
        for (int i = 0; i < NUM_GR; i++)
        begin
            next_gr[i] = gr[i];
            if (hit(reg_write, reg_addr, gr_offset(i)))
                next_gr[i] = reg_wdata[CNT_W-1:0];
            if (capture_pulse[i])
                next_gr[i] = cap_word[i];
        end
    end

    always_ff @(posedge clock)
    begin
        for (int i = 0; i < NUM_GR; i++)
        begin
            if (rst)
                gr[i] <= tcio_pkg::GR_RESET[CNT_W-1:0];
            else
                gr[i] <= next_gr[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-register units.

    for (genvar g = 0; g < NUM_GR; g++)
    begin : g_unit
        assign chan[g].field      = fields[g];
        assign chan[g].field_load = field_load[g];
        assign chan[g].buffer_off = buffered[g];
        assign chan[g].gr         = gr[g];
        assign chan[g].count      = ch0_count;
        assign chan[g].ch1_step   = ch1_count_step;
        assign chan[g].pin_in     = ch0_pin_in[g];
        assign lvl[g]             = chan[g].pin_level;
        assign oe[g]              = chan[g].pin_oe;
        assign match_pulse[g]     = chan[g].match_pulse;
        assign capture_pulse[g]   = chan[g].cap_strobe;
        assign cap_word[g]        = chan[g].cap_value;
        assign cap_mode[g]        = (tcio_pkg::field_kind(fields[g]) == tcio_pkg::KIND_CAPTURE)
                                  && !buffered[g];

        tcio_gr_unit #(
            .CNT_W (CNT_W)
        ) u_unit (
            .clock (clock),
            .rst   (rst),
            .ch    (chan[g])
        );
    end

    // Pins show the unit levels whether or not the unit drives them; the enables go out alongside.
    assign ch0_pin_out = lvl;
    assign ch0_pin_oe  = oe;

    ////////////////////////////////////////////////////////////////////////////////
    // Read port.

    // Status: enables, levels and which registers are capturing.
    always_comb
    begin
        status_word = '0;
        status_word[tcio_pkg::ST_OE_LSB  +: NUM_GR] = oe;
        status_word[tcio_pkg::ST_LVL_LSB +: NUM_GR] = lvl;
        status_word[tcio_pkg::ST_CAP_LSB +: NUM_GR] = cap_mode;
    end

    // Read data stands for one cycle only; unmapped offsets read zero.
    always_comb
    begin
        next_rdata = tcio_pkg::DATA_RESET;
        if (reg_read)
        begin
            unique case (reg_addr)
                tcio_pkg::OFS_SEL_HIGH: next_rdata = {8'h00, ch0_io_select_high};
                tcio_pkg::OFS_SEL_LOW:  next_rdata = {8'h00, ch0_io_select_low};
                tcio_pkg::OFS_GR_A:     next_rdata = 16'(gr[0]);
                tcio_pkg::OFS_GR_B:     next_rdata = 16'(gr[1]);
                tcio_pkg::OFS_GR_C:     next_rdata = 16'(gr[2]);
                tcio_pkg::OFS_GR_D:     next_rdata = 16'(gr[3]);
                tcio_pkg::OFS_STATUS:   next_rdata = status_word;
                default:                next_rdata = tcio_pkg::DATA_RESET;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            reg_rdata <= tcio_pkg::DATA_RESET;
        else
            reg_rdata <= next_rdata;
    end
endmodule

// >>> rtl/tcio_pkg.sv
// Summary of operation
// - High select: B field 7-4, A field 3-0.
// - Low select: D field 7-4, C field 3-0.
// - Code 0000: compare, pin disabled, reset value.
// - 0001-0011: start low; match drives 0/1/toggle.
// - 0100 disabled init 1; 0101-0111 start high.
// - Code 1000: capture on pin rising edge.
// - Code 1001: capture on pin falling edge.
// - 101x both edges; 11xx channel 1 count.
// - Buffer B on: D field ignored, inert.
// - Buffer A on: C field ignored, inert.
// - Selects clear on power-on reset, standby.
package tcio_pkg;

    // Register offsets on the plain register port.
    localparam logic [3:0] OFS_SEL_HIGH = 4'h0;
    localparam logic [3:0] OFS_SEL_LOW  = 4'h1;
    localparam logic [3:0] OFS_GR_A     = 4'h2;
    localparam logic [3:0] OFS_GR_B     = 4'h3;
    localparam logic [3:0] OFS_GR_C     = 4'h4;
    localparam logic [3:0] OFS_GR_D     = 4'h5;
    localparam logic [3:0] OFS_STATUS   = 4'h6;

    // Field layout inside the two select registers.
    localparam int         FIELD_W      = 4;
    localparam int         FIELD_HI_LSB = 4;
    localparam int         FIELD_LO_LSB = 0;

    // Values after reset.
    localparam logic [7:0]  SEL_RESET   = 8'h00;
    localparam logic [3:0]  FIELD_RESET = 4'h0;
    localparam logic [15:0] GR_RESET    = 16'hffff;
    localparam logic [15:0] DATA_RESET  = 16'h0000;

    // Bit meanings inside one function field.
    localparam int         CAP_BIT      = 3;
    localparam int         INIT_BIT     = 2;
    localparam int         SRC_BIT      = 2;
    localparam logic [1:0] ACT_NONE     = 2'b00;
    localparam logic [1:0] ACT_LOW      = 2'b01;
    localparam logic [1:0] ACT_HIGH     = 2'b10;
    localparam logic [1:0] ACT_TOGGLE   = 2'b11;
    localparam logic [1:0] EDGE_RISE    = 2'b00;
    localparam logic [1:0] EDGE_FALL    = 2'b01;
    localparam logic [1:0] EDGE_BOTH_A  = 2'b10;
    localparam logic [1:0] EDGE_BOTH_B  = 2'b11;

    // Status register layout.
    localparam int         ST_OE_LSB    = 0;
    localparam int         ST_LVL_LSB   = 4;
    localparam int         ST_CAP_LSB   = 8;

    typedef enum logic [0:0] {
        KIND_COMPARE = 1'b0,
        KIND_CAPTURE = 1'b1
    } tcio_kind_t;

    // Top bit of a field splits compare codes from capture codes.
    function automatic tcio_kind_t field_kind(input logic [3:0] code);
        field_kind = code[CAP_BIT] ? KIND_CAPTURE : KIND_COMPARE;
    endfunction

endpackage

// >>> rtl/tcio_ch_if.sv
`timescale 1ns/100ps
// Signals between the control top and one general-register unit.
interface tcio_ch_if #(
    parameter int CNT_W = 16
);
    logic [3:0]       field;
    logic             field_load;
    logic             buffer_off;
    logic [CNT_W-1:0] gr;
    logic [CNT_W-1:0] count;
    logic             ch1_step;
    logic             pin_in;
    logic             pin_level;
    logic             pin_oe;
    logic             match_pulse;
    logic             cap_strobe;
    logic [CNT_W-1:0] cap_value;

    modport ctrl (
        output field, field_load, buffer_off, gr, count, ch1_step, pin_in,
        input  pin_level, pin_oe, match_pulse, cap_strobe, cap_value
    );
    modport unit (
        input  field, field_load, buffer_off, gr, count, ch1_step, pin_in,
        output pin_level, pin_oe, match_pulse, cap_strobe, cap_value
    );
endinterface

// >>> rtl/tcio_edge.sv
`timescale 1ns/100ps
// Edge detector on a pin that is already synchronous to the clock.
module tcio_edge (
    input  logic clock,
    input  logic rst,
    input  logic pin_in,
    output logic rise,
    output logic fall
);
    logic prev;
    logic next_prev;

    // The previous sample follows the pin during reset, so no false edge comes after it.
    always_comb
    begin
        next_prev = pin_in;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            prev <= pin_in;
        else
            prev <= next_prev;
    end

    // Edges are decoded from the current and previous sample.
    assign rise = pin_in & ~prev;
    assign fall = ~pin_in & prev;
endmodule

// >>> rtl/tcio_gr_unit.sv
`timescale 1ns/100ps
// Compare and capture logic for one general register.
module tcio_gr_unit #(
    parameter int CNT_W = 16
) (
    input  logic    clock,
    input  logic    rst,
    tcio_ch_if.unit ch
);
    logic [3:0]              eff;
    tcio_pkg::tcio_kind_t    kind;
    logic                    rise;
    logic                    fall;
    logic                    match;
    logic                    cap_event;
    logic [CNT_W-1:0]        prev_count;
    logic [CNT_W-1:0]        next_prev_count;
    logic                    next_level;
    logic                    next_oe;
    logic                    next_match;
    logic                    next_cap;
    logic [CNT_W-1:0]        next_cap_value;

    tcio_edge u_edge (
        .clock  (clock),
        .rst    (rst),
        .pin_in (ch.pin_in),
        .rise   (rise),
        .fall   (fall)
    );

    // A buffered register sees the reset code in its field and raises no match pulse.
    always_comb
    begin
        eff  = ch.buffer_off ? tcio_pkg::FIELD_RESET : ch.field;
        kind = tcio_pkg::field_kind(eff);
        // Match only on arrival at the value, so a stopped counter toggles once.
        match = (kind == tcio_pkg::KIND_COMPARE) && !ch.buffer_off
              && (ch.count == ch.gr) && (ch.count != prev_count);
        cap_event = 1'b0;
        if (kind == tcio_pkg::KIND_CAPTURE)
        begin
            if (eff[tcio_pkg::SRC_BIT])
                cap_event = ch1_step_q(ch.ch1_step);
            else
            begin
                unique case (eff[1:0])
                    tcio_pkg::EDGE_RISE:   cap_event = rise;
                    tcio_pkg::EDGE_FALL:   cap_event = fall;
                    tcio_pkg::EDGE_BOTH_A: cap_event = rise | fall;
                    tcio_pkg::EDGE_BOTH_B: cap_event = rise | fall;
                endcase
            end
        end
    end

    function automatic logic ch1_step_q(input logic step);
        ch1_step_q = step;
    endfunction

    // Pin level: a field write loads the initial level, a match acts on it.
    always_comb
    begin
        next_level = ch.pin_level;
        if (ch.field_load)
            next_level = (kind == tcio_pkg::KIND_COMPARE) && eff[tcio_pkg::INIT_BIT];
        else if (match)
        begin
            unique case (eff[1:0])
                tcio_pkg::ACT_NONE:   next_level = ch.pin_level;
                tcio_pkg::ACT_LOW:    next_level = 1'b0;
                tcio_pkg::ACT_HIGH:   next_level = 1'b1;
                tcio_pkg::ACT_TOGGLE: next_level = ~ch.pin_level;
            endcase
        end
        next_oe = (kind == tcio_pkg::KIND_COMPARE) && (eff[1:0] != tcio_pkg::ACT_NONE);
        next_match      = match;
        next_cap        = cap_event;
        next_cap_value  = cap_event ? ch.count : ch.cap_value;
        next_prev_count = ch.count;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ch.pin_level   <= 1'b0;
            ch.pin_oe      <= 1'b0;
            ch.match_pulse <= 1'b0;
            ch.cap_strobe  <= 1'b0;
            ch.cap_value   <= tcio_pkg::DATA_RESET[CNT_W-1:0];
            prev_count     <= tcio_pkg::DATA_RESET[CNT_W-1:0];
        end
        else
        begin
            ch.pin_level   <= next_level;
            ch.pin_oe      <= next_oe;
            ch.match_pulse <= next_match;
            ch.cap_strobe  <= next_cap;
            ch.cap_value   <= next_cap_value;
            prev_count     <= next_prev_count;
        end
    end
endmodule

// >>> sim/tcio_pins.sv
`timescale 1ns/100ps
// Far side of the four channel pins: a pin that the block drives carries
// the block's level, any other pin carries the external source level.
module tcio_pins (
    input  logic [3:0] pin_out,
    input  logic [3:0] pin_oe,
    input  logic [3:0] ext_level,
    output logic [3:0] wire_level
);
    // The external source backs off while the block drives, so no fight.
    assign wire_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// >>> sim/tcio_top_sva.sv
`timescale 1ns/100ps
// Port-level checks of the register-function block.
module tcio_top_sva #(
    parameter int CNT_W = 16
) (
    input logic             clock,
    input logic             rst,
    input logic             standby,
    input logic [3:0]       reg_addr,
    input logic [15:0]      reg_wdata,
    input logic             reg_write,
    input logic             reg_read,
    input logic [15:0]      reg_rdata,
    input logic [CNT_W-1:0] ch0_count,
    input logic             ch1_count_step,
    input logic             buffer_a_enable,
    input logic             buffer_b_enable,
    input logic [3:0]       ch0_pin_in,
    input logic [3:0]       ch0_pin_out,
    input logic [3:0]       ch0_pin_oe,
    input logic [3:0]       match_pulse,
    input logic [3:0]       capture_pulse
);
    // One clock domain; every check pauses while reset is high.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    // Select write, one quiet cycle, then its read-back.
    sequence sel_wr_rd_s;
        reg_write && reg_addr == tcio_pkg::OFS_SEL_HIGH && !standby
        ##1 !reg_write && !standby
        ##1 reg_read && reg_addr == tcio_pkg::OFS_SEL_HIGH && !standby;
    endsequence
    // Standby, a quiet cycle, then a read of either select.
    sequence stby_rd_s;
        standby ##1 !standby && !reg_write ##1 reg_read && reg_addr[3:1] == 3'h0;
    endsequence
    ////////////////////////////////////////////////////////////
    sel_readback_a: assert property (
        sel_wr_rd_s |=> reg_rdata[7:0] == $past(reg_wdata[7:0], 3))
        else $error("select read-back differs from write");
    standby_clear_a: assert property (
        stby_rd_s |=> reg_rdata == 16'h0000)
        else $error("select not cleared by standby");
    buf_c_inert_a: assert property (
        buffer_a_enable && $past(buffer_a_enable) && $past(buffer_a_enable, 2)
        |-> !match_pulse[2] && !capture_pulse[2] && !ch0_pin_oe[2])
        else $error("register C active while buffered");
    buf_d_inert_a: assert property (
        buffer_b_enable && $past(buffer_b_enable) && $past(buffer_b_enable, 2)
        |-> !match_pulse[3] && !capture_pulse[3] && !ch0_pin_oe[3])
        else $error("register D active while buffered");
    match_cause_a: assert property (
        match_pulse[0] |-> $past(ch0_count) != $past(ch0_count, 2))
        else $error("match without a newly arrived count");
    capture_cause_a: assert property (
        capture_pulse[1] |-> $past(ch1_count_step)
        || $past(ch0_pin_in[1]) != $past(ch0_pin_in[1], 2))
        else $error("capture without pin edge or count step");
    oe_cause_a: assert property (
        $changed(ch0_pin_oe[1:0]) |-> $past(reg_write, 2) || $past(standby, 2)
        || $past(rst) || $past(rst, 2))
        else $error("pin enable moved without a select change");
    level_cause_a: assert property (
        $changed(ch0_pin_out[0]) |-> match_pulse[0] || $past(reg_write, 2)
        || $past(standby, 2) || $past(rst))
        else $error("pin level moved without match or select write");
endmodule

// >>> sim/tcio_top_test.sv
`timescale 1ns/100ps
// Self-checking bench: selects, compare pins, captures, buffers, standby.
module tcio_top_test;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        standby = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [15:0] reg_rdata;
    logic [15:0] ch0_count = 16'h0000;
    logic        ch1_count_step = 1'b0;
    logic        buffer_a_enable = 1'b0;
    logic        buffer_b_enable = 1'b0;
    logic [3:0]  ch0_pin_in;
    logic [3:0]  ch0_pin_out;
    logic [3:0]  ch0_pin_oe;
    logic [3:0]  match_pulse;
    logic [3:0]  capture_pulse;
    logic [3:0]  ext_level = 4'h0;
    int          fail_count = 0;
    int          checked = 0;

    tcio_top i_dut (.*);
    tcio_pins i_pins (
        .pin_out    (ch0_pin_out),
        .pin_oe     (ch0_pin_oe),
        .ext_level  (ext_level),
        .wire_level (ch0_pin_in)
    );
    // Free-running clock at 40 MHz.
    always #12.5 clock = ~clock;
    ////////////////////////////////////////////////////////////
    // Verdict and the single end of the run.
    task automatic summarize;
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Case equality, so an unknown never passes for a match.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH time=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Step past n edges so that registered outputs have landed.
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // One-cycle write strobe; the block takes it at the second edge.
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe.
    task automatic rc(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    // Move one external pin; expect a capture of count v, or none.
    task automatic pin_edge(input int i, input logic lvl, input logic exp,
                            input logic [15:0] v);
        @(posedge clock);
        ext_level[i] <= lvl;
        ch0_count <= v;
        tick(1);
        chk(16'(capture_pulse[i]), 16'(exp));
        if (exp)
            rc(tcio_pkg::OFS_GR_A + 4'(i), v);
    endtask
    ////////////////////////////////////////////////////////////
    // Reset values, and an unmapped offset that must read zero.
    task automatic t_reset;
        rc(tcio_pkg::OFS_SEL_HIGH, 16'h0000);
        rc(tcio_pkg::OFS_SEL_LOW, 16'h0000);
        rc(4'hf, 16'h0000);
        chk(16'(ch0_pin_oe), 16'h0000);
    endtask
    // Every compare code on register A: start level, enable, match action.
    task automatic t_compare;
        logic lvl;
        wr(tcio_pkg::OFS_GR_A, 16'h0040);
        for (int c = 0; c < 8; c++)
        begin
            wr(tcio_pkg::OFS_SEL_HIGH, 16'(c));
            tick(2);
            lvl = c[2];
            chk(16'(ch0_pin_out[0]), 16'(lvl));
            chk(16'(ch0_pin_oe[0]), 16'(c[1:0] != 2'b00));
            @(posedge clock);
            ch0_count <= 16'h0040;
            tick(1);
            if (c[1:0] != 2'b00)
                lvl = (c[1:0] == 2'b11) ? ~lvl : c[1];
            chk(16'(match_pulse[0]), 16'h0001);
            chk(16'(ch0_pin_out[0]), 16'(lvl));
            tick(1);
            chk(16'(match_pulse[0]), 16'h0000);
            @(posedge clock);
            ch0_count <= 16'h0000;
        end
    endtask
    // Pin-edge and channel 1 capture codes on register B.
    task automatic t_capture;
        for (int c = 8; c < 16; c++)
        begin
            wr(tcio_pkg::OFS_SEL_HIGH, 16'(c << 4));
            tick(2);
            pin_edge(1, 1'b1, !c[2] && c != 9, 16'h1200 + 16'(c));
            pin_edge(1, 1'b0, !c[2] && c != 8, 16'h1300 + 16'(c));
            @(posedge clock);
            ch1_count_step <= 1'b1;
            ch0_count <= 16'h1400 + 16'(c);
            @(posedge clock);
            ch1_count_step <= 1'b0;
            #1;
            chk(16'(capture_pulse[1]), 16'(c[2]));
        end
        rc(tcio_pkg::OFS_GR_B, 16'h140f);
    endtask
    // Buffer bits leave C and D inert whatever their fields hold.
    task automatic t_buffer;
        @(posedge clock);
        buffer_a_enable <= 1'b1;
        buffer_b_enable <= 1'b1;
        wr(tcio_pkg::OFS_GR_C, 16'h0050);
        wr(tcio_pkg::OFS_SEL_LOW, 16'h0081);
        tick(2);
        chk(16'(ch0_pin_oe[2]), 16'h0000);
        @(posedge clock);
        ch0_count <= 16'h0050;
        tick(1);
        chk(16'(match_pulse[2]), 16'h0000);
        pin_edge(3, 1'b1, 1'b0, 16'h1500);
        @(posedge clock);
        buffer_a_enable <= 1'b0;
        buffer_b_enable <= 1'b0;
        tick(2);
        chk(16'(ch0_pin_oe[2]), 16'h0001);
        // Status: C enabled, nothing high, B and D in capture mode.
        rc(tcio_pkg::OFS_STATUS, 16'h0a04);
        pin_edge(3, 1'b0, 1'b0, 16'h1600);
        pin_edge(3, 1'b1, 1'b1, 16'h1700);
    endtask
    // Standby clears both selects and overrides a write made meanwhile.
    task automatic t_standby;
        wr(tcio_pkg::OFS_SEL_HIGH, 16'h00a5);
        rc(tcio_pkg::OFS_SEL_HIGH, 16'h00a5);
        @(posedge clock);
        standby <= 1'b1;
        wr(tcio_pkg::OFS_SEL_LOW, 16'h0033);
        standby <= 1'b0;
        rc(tcio_pkg::OFS_SEL_HIGH, 16'h0000);
        rc(tcio_pkg::OFS_SEL_LOW, 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////
    // Main sequence: ten cycles of reset, then every scenario in turn.
    initial
    begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_compare();
        t_capture();
        t_buffer();
        t_standby();
        summarize();
    end
    // The scenarios need under a thousand cycles; a hang ends here.
    initial
    begin
        repeat (4000) @(posedge clock);
        fail_count++;
        summarize();
    end
endmodule

bind tcio_top tcio_top_sva #(.CNT_W(CNT_W)) i_sva (.*);
